// ### common/cam_pkg.sv
// shared constants and types for the cpu arithmetic datapath
package cam_pkg;
   localparam int DW   = 16;
   localparam int NREG = 16;

   // register port map
   localparam logic [3:0]  ADDR_CTL      = 4'h0;
   localparam logic [3:0]  ADDR_FLAGS    = 4'h1;
   localparam int          CTL_PRIO_BIT  = 3;
   localparam int          CTL_PSV_BIT   = 2;
   localparam logic [15:0] CTL_RESET     = 16'h0000;
   localparam logic [15:0] CTL_RSVD_MASK = 16'hfff3;

   // flag register layout
   localparam int          FLG_C     = 0;
   localparam int          FLG_Z     = 1;
   localparam int          FLG_OV    = 2;
   localparam int          FLG_N     = 3;
   localparam int          FLG_DC    = 8;
   localparam logic [15:0] FLG_MASK  = 16'h010f;
   localparam logic [15:0] FLG_RESET = 16'h0000;

   // operation codes
   localparam logic [3:0] OP_ADD = 4'h0;
   localparam logic [3:0] OP_SUB = 4'h1;
   localparam logic [3:0] OP_AND = 4'h2;
   localparam logic [3:0] OP_OR  = 4'h3;
   localparam logic [3:0] OP_XOR = 4'h4;
   localparam logic [3:0] OP_ASR = 4'h5;
   localparam logic [3:0] OP_SL  = 4'h6;
   localparam logic [3:0] OP_LSR = 4'h7;
   localparam logic [3:0] OP_MUL = 4'h8;
   localparam logic [3:0] OP_DIV = 4'h9;

   // multiply modes (first letter: a operand, second: b operand)
   localparam logic [2:0] MUL_SS   = 3'h0;
   localparam logic [2:0] MUL_UU   = 3'h1;
   localparam logic [2:0] MUL_SU   = 3'h2;
   localparam logic [2:0] MUL_US   = 3'h3;
   localparam logic [2:0] MUL_SLIT = 3'h4;
   localparam logic [2:0] MUL_ULIT = 3'h5;
   localparam logic [2:0] MUL_BB   = 3'h6;

   // divide mode bits and timing
   localparam int         DIV_SIGNED_BIT = 0;
   localparam int         DIV_LONG_BIT   = 1;
   localparam int         DIV_ITERS      = 16;
   localparam int         DIV_CYCLES     = 19;
   localparam logic [3:0] ITER_LAST      = 4'(DIV_ITERS - 1);
   localparam logic [4:0] FIX_COUNT      = 5'(DIV_CYCLES - 2);
   localparam logic [3:0] QUOT_REG       = 4'h0;
   localparam logic [3:0] REM_REG        = 4'h1;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_ITER  = 4'b0100,
      ST_FIX   = 4'b1000
   } cam_div_e;
endpackage : cam_pkg

// ### src/cam_alu.sv
// cpu arithmetic datapath: alu, shifter, multiplier, divider, cpu control
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
module cam_alu
   import cam_pkg::*;
(
   input  logic        clock,
   input  logic        rst,
   input  logic        ce,
   input  logic [3:0]  reg_addr,
   input  logic [15:0] reg_wdata,
   input  logic        reg_wr,
   input  logic        reg_rd,
   output logic [15:0] reg_rdata_r,
   input  logic        prio_high_set,
   output logic        prio_high_r,
   output logic        user_irq_block_r,
   output logic        psv_enable_r,
   input  logic        op_start,
   input  logic [3:0]  op_code,
   input  logic        op_byte,
   input  logic [2:0]  op_mode,
   input  logic [4:0]  op_lit,
   input  logic [3:0]  src_a,
   input  logic [3:0]  src_b,
   input  logic        src_b_mem,
   input  logic [15:0] mem_rdata,
   input  logic [3:0]  dst,
   input  logic        dst_mem,
   input  logic        div_hold,
   input  logic        wreg_wr,
   input  logic [3:0]  wreg_idx,
   input  logic [15:0] wreg_wdata,
   input  logic [3:0]  wreg_rd_idx,
   output logic [15:0] wreg_rdata_r,
   output logic        mem_wr_r,
   output logic [15:0] mem_wdata_r,
   output logic        mem_byte_r,
   output logic [15:0] result_r,
   output logic        done_r,
   output logic        reject_r,
   output logic        busy_r,
   output logic [15:0] flags_r
);
   cam_div_e          state_r;
   logic [15:0]       wreg_r [NREG];
   logic [15:0]       a_val;
   logic [15:0]       b_val;
   logic [15:0]       bx;
   logic [15:0]       alu_res;
   logic [15:0]       ctl_word;
   logic [16:0]       sum17;
   logic [8:0]        sum9;
   logic [4:0]        sum5;
   logic              is_sub;
   logic              is_mul;
   logic              is_div;
   logic              shift_op;
   logic              arith_op;
   logic              take;
   logic              refuse;
   logic              do_op;
   logic              res_c;
   logic              res_ov;
   logic              res_dc;
   logic              res_z;
   logic              res_n;
   logic              prio_nxt;
   logic              sa;
   logic              sb;
   logic [16:0]       ma;
   logic [16:0]       mb;
   logic signed [33:0] prod;
   logic [31:0]       dvd_r;
   logic [15:0]       dvs_r;
   logic [15:0]       q_r;
   logic [17:0]       p_r;
   logic              sgn_r;
   logic              neg_q_r;
   logic              neg_r_r;
   logic [3:0]        cnt_r;
   logic [4:0]        act_cnt_r;
   logic [31:0]       dvd_in;
   logic [31:0]       dvd_abs;
   logic [15:0]       dvs_abs;
   logic [15:0]       quot_fin;
   logic [15:0]       rem_fin;
   logic [17:0]       d18;
   logic [17:0]       p_sh;
   logic [17:0]       p_step;
   logic [17:0]       p_fix;
   logic              fix_go;

   // operand selection: a is always a register, b may come from memory
   assign a_val = wreg_r[src_a];
   assign b_val = src_b_mem ? mem_rdata : wreg_r[src_b];

   // decode
   assign is_sub   = (op_code == OP_SUB);
   assign is_mul   = (op_code == OP_MUL);
   assign is_div   = (op_code == OP_DIV);
   assign arith_op = (op_code == OP_ADD) || is_sub;
   assign shift_op = (op_code == OP_ASR) || (op_code == OP_SL) || (op_code == OP_LSR);
   assign take     = op_start && (state_r == ST_IDLE);
   // shifts never see memory; divide writes only the fixed pair
   assign refuse   = (op_code > OP_DIV)
                   || (shift_op && (src_b_mem || dst_mem))
                   || ((is_mul || is_div) && dst_mem)
                   || (is_div && src_b_mem);
   assign do_op    = take && !refuse;

   // adder: subtract is a + ~b + 1, so carry high means no borrow
   assign bx    = is_sub ? ~b_val : b_val;
   assign sum17 = {1'b0, a_val} + {1'b0, bx} + {16'h0000, is_sub};
   assign sum9  = {1'b0, a_val[7:0]} + {1'b0, bx[7:0]} + {8'h00, is_sub};
   assign sum5  = {1'b0, a_val[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub};

   // result and flag selection per width
   always_comb begin
      alu_res = 16'h0000;
      unique case (op_code)
         OP_ADD, OP_SUB: alu_res = sum17[15:0];
         OP_AND: alu_res = a_val & b_val;
         OP_OR:  alu_res = a_val | b_val;
         OP_XOR: alu_res = a_val ^ b_val;
         // barrel shifts, amount from b low nibble
         // casts keep the shift signed; an unsigned arm would turn it logical
         OP_ASR: alu_res = op_byte ? {8'h00, 8'($signed(a_val[7:0]) >>> b_val[3:0])}
                                   : 16'($signed(a_val) >>> b_val[3:0]);
         OP_SL:  alu_res = a_val << b_val[3:0];
         OP_LSR: alu_res = op_byte ? {8'h00, a_val[7:0] >> b_val[3:0]}
                                   : a_val >> b_val[3:0];
         default: alu_res = 16'h0000;
      endcase
      res_c  = op_byte ? sum9[8] : sum17[16];
      res_dc = op_byte ? sum5[4] : sum9[8];
      res_ov = op_byte ? (a_val[7] == bx[7]) && (sum9[7] != a_val[7])
                       : (a_val[15] == bx[15]) && (sum17[15] != a_val[15]);
      res_z  = op_byte ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
      res_n  = op_byte ? alu_res[7] : alu_res[15];
   end

   // 17x17 signed core; the extra bit carries sign or zero
   always_comb begin
      sa = (op_mode == MUL_SS) || (op_mode == MUL_SU) || (op_mode == MUL_SLIT);
      sb = (op_mode == MUL_SS) || (op_mode == MUL_US);
      ma = {sa & a_val[15], a_val};
      mb = {sb & b_val[15], b_val};
      if ((op_mode == MUL_SLIT) || (op_mode == MUL_ULIT)) begin
         mb = {12'h000, op_lit};
      end
      if (op_mode == MUL_BB) begin
         ma = {9'h000, a_val[7:0]};
         mb = {9'h000, b_val[7:0]};
      end
   end
   assign prod = $signed(ma) * $signed(mb);

   // divider datapath on magnitudes, signs fixed at the end
   assign dvd_in = op_mode[DIV_LONG_BIT]
                 ? {wreg_r[{src_a[3:1], 1'b1}], wreg_r[{src_a[3:1], 1'b0}]}
                 : {{16{op_mode[DIV_SIGNED_BIT] & a_val[15]}}, a_val};
   assign dvd_abs  = (sgn_r && dvd_r[31]) ? 32'h00000000 - dvd_r : dvd_r;
   assign dvs_abs  = (sgn_r && dvs_r[15]) ? 16'h0000 - dvs_r : dvs_r;
   assign d18      = {2'b00, dvs_r};
   assign p_sh     = {p_r[16:0], q_r[15]};
   // non-restoring step: add when the partial remainder is negative
   assign p_step   = p_r[17] ? p_sh + d18 : p_sh - d18;
   assign p_fix    = p_r[17] ? p_r + d18 : p_r;
   assign quot_fin = neg_q_r ? 16'h0000 - q_r : q_r;
   assign rem_fin  = neg_r_r ? 16'h0000 - p_fix[15:0] : p_fix[15:0];
   assign fix_go   = (state_r == ST_FIX) && !div_hold;

   // divide sequencer; div_hold freezes it in every state but ST_IDLE, so it cannot hold back the start
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= ST_IDLE;
         dvd_r   <= 32'h00000000;
         dvs_r   <= 16'h0000;
         q_r     <= 16'h0000;
         p_r     <= 18'h00000;
         sgn_r   <= 1'b0;
         neg_q_r <= 1'b0;
         neg_r_r <= 1'b0;
         cnt_r   <= 4'h0;
      end else if (ce) begin
         unique case (state_r)
            ST_IDLE: if (do_op && is_div) begin
               dvd_r   <= dvd_in;
               dvs_r   <= wreg_r[src_b];
               sgn_r   <= op_mode[DIV_SIGNED_BIT];
               state_r <= ST_SETUP;
            end
            ST_SETUP: if (!div_hold) begin
               neg_q_r <= sgn_r & (dvd_r[31] ^ dvs_r[15]);
               neg_r_r <= sgn_r & dvd_r[31];
               p_r     <= {2'b00, dvd_abs[31:16]};
               q_r     <= dvd_abs[15:0];
               dvs_r   <= dvs_abs;
               cnt_r   <= 4'h0;
               state_r <= ST_ITER;
            end
            // same iteration count whatever the dividend width
            ST_ITER: if (!div_hold) begin
               p_r   <= p_step;
               q_r   <= {q_r[14:0], ~p_step[17]};
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == ITER_LAST) begin
                  state_r <= ST_FIX;
               end
            end
            ST_FIX: if (!div_hold) begin
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // active-cycle count of the divide, read only by a check
   always_ff @(posedge clock) begin
      if (rst) begin
         act_cnt_r <= 5'h00;
      end else if (ce) begin
         if (state_r == ST_IDLE) begin
            act_cnt_r <= 5'h00;
         end else if (!div_hold) begin
            act_cnt_r <= act_cnt_r + 5'h01;
         end
      end
   end

   // working register array; byte writes keep the upper byte
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) begin
            wreg_r[i] <= 16'h0000;
         end
      end else if (ce) begin
         if (wreg_wr) begin
            wreg_r[wreg_idx] <= wreg_wdata;
         end
         if (do_op && !is_div && !dst_mem) begin
            if (is_mul && (op_mode != MUL_BB)) begin
               wreg_r[{dst[3:1], 1'b0}] <= prod[15:0];
               wreg_r[{dst[3:1], 1'b1}] <= prod[31:16];
            end else if (is_mul) begin
               wreg_r[dst] <= prod[15:0];
            end else if (op_byte) begin
               wreg_r[dst][7:0] <= alu_res[7:0];
            end else begin
               wreg_r[dst] <= alu_res;
            end
         end
         if (fix_go) begin
            wreg_r[QUOT_REG] <= quot_fin;
            wreg_r[REM_REG]  <= rem_fin;
         end
      end
   end

   // result strobes toward decoder and data memory
   always_ff @(posedge clock) begin
      if (rst) begin
         result_r    <= 16'h0000;
         done_r      <= 1'b0;
         reject_r    <= 1'b0;
         busy_r      <= 1'b0;
         mem_wr_r    <= 1'b0;
         mem_wdata_r <= 16'h0000;
         mem_byte_r  <= 1'b0;
      end else if (ce) begin
         done_r   <= 1'b0;
         reject_r <= take && refuse;
         mem_wr_r <= 1'b0;
         busy_r   <= (state_r == ST_IDLE) ? (do_op && is_div) : !fix_go;
         if (do_op && !is_div) begin
            done_r   <= 1'b1;
            result_r <= is_mul ? prod[15:0] : alu_res;
            if (dst_mem) begin
               mem_wr_r    <= 1'b1;
               mem_wdata_r <= alu_res;
               mem_byte_r  <= op_byte;
            end
         end
         if (fix_go) begin
            done_r   <= 1'b1;
            result_r <= quot_fin;
         end
      end
   end

   // flags: the bits an operation updates in the same cycle override a software write; a multiply updates none
   always_ff @(posedge clock) begin
      if (rst) begin
         flags_r <= FLG_RESET;
      end else if (ce) begin
         if (reg_wr && (reg_addr == ADDR_FLAGS)) begin
            flags_r <= reg_wdata & FLG_MASK;
         end
         if (do_op && arith_op) begin
            flags_r[FLG_C]  <= res_c;
            flags_r[FLG_OV] <= res_ov;
            flags_r[FLG_DC] <= res_dc;
         end
         if (do_op && !is_div && !is_mul) begin
            flags_r[FLG_Z] <= res_z;
            flags_r[FLG_N] <= res_n;
         end
         if (fix_go) begin
            flags_r[FLG_Z] <= (quot_fin == 16'h0000);
            flags_r[FLG_N] <= quot_fin[15];
         end
      end
   end

   // priority-high bit: a hardware set beats a software clear
   always_comb begin
      prio_nxt = prio_high_r;
      if (reg_wr && (reg_addr == ADDR_CTL) && !reg_wdata[CTL_PRIO_BIT]) begin
         prio_nxt = 1'b0;
      end
      if (prio_high_set) begin
         prio_nxt = 1'b1;
      end
   end

   // control register bits and the interrupt block they imply
   always_ff @(posedge clock) begin
      if (rst) begin
         prio_high_r      <= 1'b0;
         user_irq_block_r <= 1'b0;
         psv_enable_r     <= 1'b0;
      end else if (ce) begin
         prio_high_r      <= prio_nxt;
         user_irq_block_r <= prio_nxt;
         if (reg_wr && (reg_addr == ADDR_CTL)) begin
            psv_enable_r <= reg_wdata[CTL_PSV_BIT];
         end
      end
   end

   // read-back word; unimplemented bits stay zero
   always_comb begin
      ctl_word = CTL_RESET;
      ctl_word[CTL_PRIO_BIT] = prio_high_r;
      ctl_word[CTL_PSV_BIT]  = psv_enable_r;
   end

   // control read data valid only in the cycle after the strobe; working register read-back follows wreg_rd_idx every cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata_r  <= 16'h0000;
         wreg_rdata_r <= 16'h0000;
      end else if (ce) begin
         reg_rdata_r  <= 16'h0000;
         wreg_rdata_r <= wreg_r[wreg_rd_idx];
         if (reg_rd && (reg_addr == ADDR_CTL)) begin
            reg_rdata_r <= ctl_word;
         end else if (reg_rd && (reg_addr == ADDR_FLAGS)) begin
            reg_rdata_r <= flags_r;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_div_start;
      ce && do_op && is_div;
   endsequence

   a_ctl_rsvd_zero: assert property (
      (ce && reg_rd && reg_addr == ADDR_CTL) |=> ((reg_rdata_r & CTL_RSVD_MASK) == 16'h0000))
      else $error("control reserved bits not zero");
   a_prio_set_wins: assert property (
      (ce && prio_high_set) |=> prio_high_r)
      else $error("priority set lost");
   a_irq_block_tie: assert property (
      user_irq_block_r == prio_high_r)
      else $error("user irq block differs from priority bit");
   a_psv_write: assert property (
      (ce && reg_wr && reg_addr == ADDR_CTL) |=> (psv_enable_r == $past(reg_wdata[CTL_PSV_BIT])))
      else $error("program window enable not written");
   a_add_word: assert property (
      (ce && do_op && op_code == OP_ADD && !op_byte)
      |=> (result_r == 16'($past(a_val) + $past(b_val))) && done_r)
      else $error("word add result wrong");
   a_sub_borrow: assert property (
      (ce && do_op && is_sub && !op_byte)
      |=> (flags_r[FLG_C] == ($past(a_val) >= $past(b_val))))
      else $error("subtract borrow flag wrong");
   a_half_carry: assert property (
      (ce && do_op && op_code == OP_ADD && op_byte)
      |=> (flags_r[FLG_DC] == (({1'b0, $past(a_val[3:0])} + {1'b0, $past(b_val[3:0])}) > 5'h0f)))
      else $error("byte half carry wrong");
   a_asr_word: assert property (
      (ce && do_op && op_code == OP_ASR && !op_byte)
      |=> (result_r == 16'($signed($past(a_val)) >>> $past(b_val[3:0]))))
      else $error("arithmetic shift result wrong");
   a_shift_refuse: assert property (
      (ce && take && shift_op && (src_b_mem || dst_mem)) |=> (reject_r && !done_r && !mem_wr_r))
      else $error("memory shift not refused");
   a_div_cycles: assert property (
      fix_go |-> (act_cnt_r == FIX_COUNT))
      else $error("divide not nineteen cycles");
   a_div_busy: assert property (
      s_div_start |=> busy_r && (state_r == ST_SETUP))
      else $error("divide did not start");
endmodule : cam_alu

// ### verif/cam_mem_model.sv
// data memory word standing at the far side of the datapath
`timescale 1ns/10ps
module cam_mem_model (
   input  logic        clock,
   input  logic        rst,
   input  logic        preload_wr,
   input  logic [15:0] preload_data,
   input  logic        mem_wr_r,
   input  logic [15:0] mem_wdata_r,
   input  logic        mem_byte_r,
   output logic [15:0] mem_rdata
);
   // one word only: enough to see a result land, and to see which byte lanes move
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_rdata <= 16'h0000;
      end else if (preload_wr) begin
         mem_rdata <= preload_data;
      end else if (mem_wr_r) begin
         mem_rdata[7:0] <= mem_wdata_r[7:0];
         if (!mem_byte_r) begin
            mem_rdata[15:8] <= mem_wdata_r[15:8];
         end
      end
   end
endmodule : cam_mem_model

// ### verif/test_cam_alu.sv
// self-checking bench for the cpu arithmetic datapath
`timescale 1ns/10ps
module test_cam_alu
   import cam_pkg::*;
();
   logic        clock = 1'b0, rst = 1'b1, ce = 1'b1, pre_wr = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, prio_high_set = 1'b0, op_start = 1'b0;
   logic        op_byte = 1'b0, src_b_mem = 1'b0, dst_mem = 1'b0, div_hold = 1'b0;
   logic        wreg_wr = 1'b0;
   logic [3:0]  reg_addr = 4'h0, op_code = 4'h0, src_a = 4'h0, src_b = 4'h0, dst = 4'h0;
   logic [3:0]  wreg_idx = 4'h0, wreg_rd_idx = 4'h0;
   logic [2:0]  op_mode = 3'h0;
   logic [4:0]  op_lit = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, wreg_wdata = 16'h0000;
   logic [15:0] mem_rdata, reg_rdata_r, wreg_rdata_r, mem_wdata_r, result_r, flags_r;
   logic        prio_high_r, user_irq_block_r, psv_enable_r, mem_wr_r, mem_byte_r;
   logic        done_r, reject_r, busy_r;
   int          errors = 0, comparisons = 0;
   // expected {high, low} per multiply mode, all-ones operands and a literal of 31
   logic [31:0] mul_exp [7] = '{32'h00000001, 32'hfffe0001, 32'hffff0001, 32'hffff0001,
                                 32'hffffffe1, 32'h001effe1, 32'h0000fe01};

   cam_alu u_dut (
      .clock, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
      .prio_high_set, .prio_high_r, .user_irq_block_r, .psv_enable_r, .op_start,
      .op_code, .op_byte, .op_mode, .op_lit, .src_a, .src_b, .src_b_mem, .mem_rdata,
      .dst, .dst_mem, .div_hold, .wreg_wr, .wreg_idx, .wreg_wdata, .wreg_rd_idx,
      .wreg_rdata_r, .mem_wr_r, .mem_wdata_r, .mem_byte_r, .result_r, .done_r,
      .reject_r, .busy_r, .flags_r
   );

   cam_mem_model u_mem (
      .clock, .rst, .preload_wr(pre_wr), .preload_data(16'h1234), .mem_wr_r,
      .mem_wdata_r, .mem_byte_r, .mem_rdata
   );

   // 20 MHz
   initial begin
      forever #25 clock = ~clock;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write

   // read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, input logic [15:0] exp, input string what);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check(what, reg_rdata_r, exp);
   endtask : reg_read

   task automatic wload(input logic [3:0] i, input logic [15:0] d);
      @(posedge clock);
      wreg_wr <= 1'b1;
      wreg_idx <= i;
      wreg_wdata <= d;
      @(posedge clock);
      wreg_wr <= 1'b0;
   endtask : wload

   task automatic wpeek(input logic [3:0] i, input logic [15:0] exp, input string what);
      @(posedge clock);
      wreg_rd_idx <= i;
      @(posedge clock);
      #1;
      check(what, wreg_rdata_r, exp);
   endtask : wpeek

   task automatic setm(input logic byt, input logic bm, input logic dm, input logic [4:0] lit);
      @(posedge clock);
      op_byte <= byt;
      src_b_mem <= bm;
      dst_mem <= dm;
      op_lit <= lit;
   endtask : setm

   // n counts edges after the taking edge until done or reject shows
   task automatic op(input logic [3:0] c, input logic [2:0] m, input logic [3:0] a,
                     input logic [3:0] b, input logic [3:0] d, output int n);
      @(posedge clock);
      op_code <= c;
      op_mode <= m;
      src_a <= a;
      src_b <= b;
      dst <= d;
      op_start <= 1'b1;
      @(posedge clock);
      op_start <= 1'b0;
      n = 0;
      #1;
      while (!(done_r === 1'b1 || reject_r === 1'b1) && n < 40) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask : op

   task automatic arith(input logic [3:0] c, input logic [15:0] a, input logic [15:0] b,
                        input logic [15:0] r, input logic [15:0] f);
      int n;
      wload(4'h2, a);
      wload(4'h3, b);
      op(c, 3'h0, 4'h2, 4'h3, 4'h4, n);
      check("done", done_r, 1'b1);
      check("result", result_r, r);
      check("flags", flags_r, f);
      wpeek(4'h4, r, "dest");
   endtask : arith

   // dividend low in r8, high in r9; odd src_a for long proves pair alignment
   task automatic divide(input logic [2:0] m, input logic [15:0] hi, input logic [15:0] lo,
                         input logic [15:0] q, input logic [15:0] r, input int hold);
      int n;
      wload(4'h8, lo);
      wload(4'h9, hi);
      wload(4'ha, 16'h0007);
      if (hold != 0) begin
         fork
            begin
               repeat (4) @(posedge clock);
               #1;
               check("busy", busy_r, 1'b1);
               div_hold <= 1'b1;
               repeat (hold) @(posedge clock);
               div_hold <= 1'b0;
            end
         join_none
      end
      op(OP_DIV, m, {3'h4, m[DIV_LONG_BIT]}, 4'ha, 4'h5, n);
      check("div cycles", n, DIV_CYCLES - 1 + hold);
      check("idle", busy_r, 1'b0);
      wpeek(QUOT_REG, q, "quotient");
      wpeek(REM_REG, r, "remainder");
   endtask : divide

   // hang guard, well beyond the roughly 320 cycles the sequence needs
   initial begin
      repeat (4000) @(posedge clock);
      errors++;
      complete_run();
   end

   initial begin
      int n;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      reg_read(ADDR_CTL, 16'h0000, "ctl reset");
      reg_read(ADDR_FLAGS, 16'h0000, "flags reset");
      reg_write(ADDR_CTL, 16'hffff);
      reg_read(ADDR_CTL, 16'h0004, "ctl ones");
      check("window", psv_enable_r, 1'b1);
      @(posedge clock);
      prio_high_set <= 1'b1;
      @(posedge clock);
      prio_high_set <= 1'b0;
      #1;
      check("irq block", user_irq_block_r, 1'b1);
      check("prio bit", prio_high_r, 1'b1);
      reg_read(ADDR_CTL, 16'h000c, "ctl prio");
      reg_write(ADDR_CTL, 16'h0000);
      reg_read(ADDR_CTL, 16'h0000, "ctl clear");
      check("irq free", user_irq_block_r, 1'b0);
      // a write while the clock enable is low must not land
      @(posedge clock);
      ce <= 1'b0;
      reg_write(ADDR_CTL, 16'h0004);
      ce <= 1'b1;
      #1;
      check("frozen", psv_enable_r, 1'b0);
      reg_write(4'h7, 16'hffff);
      reg_read(4'h7, 16'h0000, "unmapped");
      reg_write(ADDR_FLAGS, 16'hffff);
      reg_read(ADDR_FLAGS, FLG_MASK, "flags mask");
      // word ops; logic and shifts leave C, OV, DC from the borrow case before them
      arith(OP_ADD, 16'h00ff, 16'h0001, 16'h0100, 16'h0100);
      arith(OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 16'h010c);
      arith(OP_ADD, 16'hffff, 16'h0001, 16'h0000, 16'h0103);
      arith(OP_SUB, 16'h0005, 16'h0003, 16'h0002, 16'h0101);
      arith(OP_SUB, 16'h0000, 16'h0001, 16'hffff, 16'h0008);
      arith(OP_AND, 16'hf0f0, 16'hff00, 16'hf000, 16'h0008);
      arith(OP_OR, 16'hf0f0, 16'h0f00, 16'hfff0, 16'h0008);
      arith(OP_XOR, 16'hff00, 16'hff00, 16'h0000, 16'h0002);
      arith(OP_ASR, 16'h8000, 16'h000f, 16'hffff, 16'h0008);
      arith(OP_SL, 16'h0001, 16'h000f, 16'h8000, 16'h0008);
      arith(OP_LSR, 16'h8000, 16'h000f, 16'h0001, 16'h0000);
      // byte add into a register keeps its upper byte
      setm(1'b1, 1'b0, 1'b0, 5'h00);
      wload(4'h4, 16'hab00);
      wload(4'h2, 16'h120f);
      wload(4'h3, 16'h0001);
      op(OP_ADD, 3'h0, 4'h2, 4'h3, 4'h4, n);
      check("byte flags", flags_r, 16'h0100);
      wpeek(4'h4, 16'hab10, "byte dest");
      // operand from memory, result to memory, word then byte
      @(posedge clock);
      pre_wr <= 1'b1;
      @(posedge clock);
      pre_wr <= 1'b0;
      setm(1'b0, 1'b1, 1'b1, 5'h00);
      wload(4'h2, 16'h0001);
      op(OP_ADD, 3'h0, 4'h2, 4'h3, 4'h4, n);
      check("mem write", mem_wr_r, 1'b1);
      @(posedge clock);
      #1;
      check("mem word", mem_rdata, 16'h1235);
      setm(1'b1, 1'b1, 1'b1, 5'h00);
      wload(4'h2, 16'h00ff);
      op(OP_ADD, 3'h0, 4'h2, 4'h3, 4'h4, n);
      check("mem byte", mem_byte_r, 1'b1);
      check("byte carry", flags_r, 16'h0101);
      @(posedge clock);
      #1;
      check("mem lane", mem_rdata, 16'h1234);
      // a shift aimed at memory is refused
      setm(1'b0, 1'b0, 1'b1, 5'h00);
      op(OP_SL, 3'h0, 4'h2, 4'h3, 4'h4, n);
      check("shift to mem", reject_r, 1'b1);
      setm(1'b0, 1'b0, 1'b0, 5'h1f);
      wload(4'h2, 16'hffff);
      wload(4'h3, 16'hffff);
      for (int i = 0; i < 7; i++) begin
         op(OP_MUL, 3'(i), 4'h2, 4'h3, 4'h6, n);
         wpeek(4'h6, mul_exp[i][15:0], "product low");
         if (i < 6) begin
            wpeek(4'h7, mul_exp[i][31:16], "product high");
         end
      end
      divide(3'h3, 16'hfffe, 16'h7960, 16'hc833, 16'hfffb, 0);
      divide(3'h2, 16'h0001, 16'h86a0, 16'h37cd, 16'h0005, 0);
      divide(3'h1, 16'hfffe, 16'hff9c, 16'hfff2, 16'hfffe, 3);
      divide(3'h0, 16'hfffe, 16'h0064, 16'h000e, 16'h0002, 3);
      complete_run();
   end
endmodule : test_cam_alu
